// >>> core/imu_top.sv
// integer multiply unit of the core datapath
`timescale 1ns/1ps
`include "imu_defines.svh"
module imu_top
    import imu_pkg::*;
#(
    parameter bit MOTOR_CTRL = 1'b1
)
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // issue request
    input wire logic issue_valid,
    input wire imu_form_t issue_form,
    input wire imu_sign_t issue_sign,
    input wire logic issue_sfr_read,
    input wire logic [3:0] issue_dest_idx,
    input wire logic issue_acc_sel,
    // operand values from the register file
    input wire logic [15:0] base_operand_register,
    input wire logic [15:0] source_operand_register,
    input wire logic [4:0] five_bit_immediate,
    input wire logic [15:0] file_word,
    input wire logic [15:0] default_working_register,
    // register file writes
    output logic wr_lo_en,
    output logic [3:0] wr_lo_idx,
    output logic [15:0] wr_lo_data,
    output logic wr_hi_en,
    output logic [3:0] wr_hi_idx,
    output logic [15:0] wr_hi_data,
    // accumulator write
    output logic acc_wr_en,
    output logic acc_wr_sel,
    output logic [39:0] acc_wr_data,
    // issue status
    output logic busy,
    output logic done,
    output logic illegal
);

    // ==========================================================
    // all state of the unit
    typedef struct packed {
        imu_phase_t phase;
        imu_form_t form;
        imu_sign_t sign;
        logic [3:0] dest_idx;
        logic acc_sel;
        logic [15:0] base_val;
        logic [15:0] source_val;
        logic [4:0] lit;
        logic wr_lo_en;
        logic [3:0] wr_lo_idx;
        logic [15:0] wr_lo_data;
        logic wr_hi_en;
        logic [3:0] wr_hi_idx;
        logic [15:0] wr_hi_data;
        logic acc_wr_en;
        logic acc_wr_sel;
        logic [39:0] acc_wr_data;
        logic busy;
        logic done;
        logic illegal;
    } imu_state_t;

    imu_state_t state;
    imu_state_t next_state;
    imu_mul_if mul_bus ();

    logic take;
    logic exec;
    imu_form_t cur_form;
    imu_sign_t cur_sign;
    logic [3:0] cur_dest;
    logic cur_acc_sel;
    logic [15:0] cur_base;
    logic [15:0] cur_source;
    logic [4:0] cur_lit;
    logic is_acc_form;
    logic is_lit_form;
    logic prod_signed;

    imu_mul_array u_array (
        .mul(mul_bus.multiplier)
    );

    // a request is taken only while no stall is running
    assign take = issue_valid && (state.phase == IMU_PH_IDLE);
    // execute now unless a peripheral read stretches the cycle
    assign exec = (take && !issue_sfr_read) || (state.phase == IMU_PH_SFR_WAIT);

    // ==========================================================
    // operands come live from issue or from the stalled copy
    always_comb
    begin
        if (state.phase == IMU_PH_SFR_WAIT)
        begin
            cur_form = state.form;
            cur_sign = state.sign;
            cur_dest = state.dest_idx;
            cur_acc_sel = state.acc_sel;
            cur_base = state.base_val;
            cur_source = state.source_val;
            cur_lit = state.lit;
        end
        else if (issue_form == IMU_FORM_FILE)
        begin
            cur_form = issue_form;
            cur_sign = IMU_SIGN_UU;
            cur_dest = issue_dest_idx;
            cur_acc_sel = issue_acc_sel;
            cur_base = file_word;
            cur_source = default_working_register;
            cur_lit = five_bit_immediate;
        end
        else
        begin
            cur_form = issue_form;
            cur_sign = issue_sign;
            cur_dest = issue_dest_idx;
            cur_acc_sel = issue_acc_sel;
            cur_base = base_operand_register;
            cur_source = source_operand_register;
            cur_lit = five_bit_immediate;
        end
    end

    // ==========================================================
    // operand steering into the multiplier array
    always_comb
    begin
        is_acc_form = (cur_form == IMU_FORM_ACC_REG) || (cur_form == IMU_FORM_ACC_LIT);
        is_lit_form = (cur_form == IMU_FORM_ACC_LIT) || (cur_form == IMU_FORM_PAIR_LIT)
            || (cur_form == IMU_FORM_WORD_LIT);
        mul_bus.base_operand = cur_base;
        // base sign from the first letter of the sign code
        mul_bus.base_signed = (cur_sign == IMU_SIGN_SS) || (cur_sign == IMU_SIGN_SU);
        if (is_lit_form)
        begin
            // literal is always zero extended and unsigned
            mul_bus.source_operand = {11'h000, cur_lit};
            mul_bus.source_signed = 1'b0;
        end
        else
        begin
            mul_bus.source_operand = cur_source;
            mul_bus.source_signed = (cur_sign == IMU_SIGN_SS) || (cur_sign == IMU_SIGN_US);
        end
        prod_signed = mul_bus.base_signed || mul_bus.source_signed;
    end

    // ==========================================================
    // next state: sequencing and result writes
    always_comb
    begin
        next_state = state;
        next_state.wr_lo_en = 1'b0;
        next_state.wr_hi_en = 1'b0;
        next_state.acc_wr_en = 1'b0;
        next_state.done = 1'b0;
        next_state.illegal = 1'b0;
        next_state.busy = 1'b0;
        case (state.phase)
            IMU_PH_IDLE:
            begin
                if (take && issue_sfr_read)
                begin
                    // hold the request for one extra cycle
                    next_state.phase = IMU_PH_SFR_WAIT;
                    next_state.busy = 1'b1;
                    next_state.form = cur_form;
                    next_state.sign = cur_sign;
                    next_state.dest_idx = cur_dest;
                    next_state.acc_sel = cur_acc_sel;
                    next_state.base_val = cur_base;
                    next_state.source_val = cur_source;
                    next_state.lit = cur_lit;
                end
            end
            IMU_PH_SFR_WAIT:
            begin
                next_state.phase = IMU_PH_IDLE;
            end
            default:
            begin
                next_state.phase = IMU_PH_IDLE;
            end
        endcase
        // single-cycle completion, sets done or illegal
        if (exec)
        begin
            next_state.done = 1'b1;
            next_state.wr_lo_data = mul_bus.product[15:0];
            next_state.wr_hi_data = mul_bus.product[31:16];
            next_state.wr_lo_idx = cur_dest;
            next_state.wr_hi_idx = cur_dest + 4'h1;
            next_state.acc_wr_sel = cur_acc_sel;
            next_state.acc_wr_data = {{8{prod_signed & mul_bus.product[31]}}, mul_bus.product};
            case (cur_form)
                IMU_FORM_PAIR_REG, IMU_FORM_PAIR_LIT:
                begin
                    next_state.wr_lo_en = 1'b1;
                    next_state.wr_hi_en = 1'b1;
                end
                IMU_FORM_WORD_REG, IMU_FORM_WORD_LIT:
                begin
                    next_state.wr_lo_en = 1'b1;
                end
                IMU_FORM_FILE:
                begin
                    next_state.wr_lo_en = 1'b1;
                    next_state.wr_hi_en = 1'b1;
                    next_state.wr_lo_idx = `IMU_FILE_LO_IDX;
                    next_state.wr_hi_idx = `IMU_FILE_HI_IDX;
                end
                default:
                begin
                    // accumulator forms exist only in motor-control builds
                    if (MOTOR_CTRL)
                    begin
                        next_state.acc_wr_en = 1'b1;
                    end
                    else
                    begin
                        next_state.illegal = 1'b1;
                        next_state.done = 1'b0;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // outputs straight from the state register
    assign wr_lo_en = state.wr_lo_en;
    assign wr_lo_idx = state.wr_lo_idx;
    assign wr_lo_data = state.wr_lo_data;
    assign wr_hi_en = state.wr_hi_en;
    assign wr_hi_idx = state.wr_hi_idx;
    assign wr_hi_data = state.wr_hi_data;
    assign acc_wr_en = state.acc_wr_en;
    assign acc_wr_sel = state.acc_wr_sel;
    assign acc_wr_data = state.acc_wr_data;
    assign busy = state.busy;
    assign done = state.done;
    assign illegal = state.illegal;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    sequence pair_ss_req;
        take && !issue_sfr_read && issue_form == IMU_FORM_PAIR_REG && issue_sign == IMU_SIGN_SS;
    endsequence

    sequence pair_uu_req;
        take && !issue_sfr_read && issue_form == IMU_FORM_PAIR_REG && issue_sign == IMU_SIGN_UU;
    endsequence

    sequence sfr_req;
        take && issue_sfr_read;
    endsequence

    pair_ss_a: assert property (pair_ss_req |=> wr_lo_en && wr_hi_en && wr_hi_idx == $past(issue_dest_idx) + 4'h1
        && $signed({wr_hi_data, wr_lo_data}) == $signed($past(base_operand_register))
        * $signed($past(source_operand_register)))
        else $error("signed pair product wrong");

    pair_su_a: assert property (take && !issue_sfr_read && issue_form == IMU_FORM_PAIR_REG
        && issue_sign == IMU_SIGN_SU |=> $signed({wr_hi_data, wr_lo_data})
        == $signed($past(base_operand_register)) * $signed({1'b0, $past(source_operand_register)}))
        else $error("signed-unsigned pair product wrong");

    pair_us_a: assert property (take && !issue_sfr_read && issue_form == IMU_FORM_PAIR_REG
        && issue_sign == IMU_SIGN_US |=> $signed({wr_hi_data, wr_lo_data})
        == $signed({1'b0, $past(base_operand_register)}) * $signed($past(source_operand_register)))
        else $error("unsigned-signed pair product wrong");

    pair_uu_a: assert property (pair_uu_req |=> {wr_hi_data, wr_lo_data}
        == $past(base_operand_register) * $past(source_operand_register))
        else $error("unsigned pair product wrong");

    word_only_a: assert property (take && !issue_sfr_read && issue_form == IMU_FORM_WORD_REG
        |=> wr_lo_en && !wr_hi_en && !acc_wr_en)
        else $error("word form wrote more than one register");

    acc_load_a: assert property (take && !issue_sfr_read && issue_form == IMU_FORM_ACC_REG
        && issue_sign == IMU_SIGN_UU |=> acc_wr_en == MOTOR_CTRL
        && acc_wr_data == $past(base_operand_register) * $past(source_operand_register))
        else $error("accumulator load wrong");

    acc_lit_a: assert property (take && !issue_sfr_read && issue_form == IMU_FORM_ACC_LIT && issue_sign == IMU_SIGN_UU
        |=> acc_wr_data[31:0] == $past(base_operand_register) * {11'h000, $past(five_bit_immediate)})
        else $error("literal accumulator product wrong");

    lit_pair_a: assert property (take && !issue_sfr_read && issue_form == IMU_FORM_PAIR_LIT
        && issue_sign == IMU_SIGN_UU |=> wr_hi_en && {wr_hi_data, wr_lo_data}
        == $past(base_operand_register) * {11'h000, $past(five_bit_immediate)})
        else $error("literal pair product wrong");

    lit_word_a: assert property (take && !issue_sfr_read && issue_form == IMU_FORM_WORD_LIT
        |=> wr_lo_en && !wr_hi_en)
        else $error("literal word form wrote the pair");

    no_acc_a: assert property (!MOTOR_CTRL |-> !acc_wr_en)
        else $error("accumulator written without motor control");

    sfr_stall_a: assert property (sfr_req |=> busy && !done ##1 !busy && (done || illegal))
        else $error("peripheral read stall not one cycle");

    one_cycle_a: assert property (take && !issue_sfr_read |=> !busy && (done || illegal))
        else $error("multiply took more than one cycle");

    file_dest_a: assert property (take && !issue_sfr_read && issue_form == IMU_FORM_FILE
        |=> wr_lo_idx == 4'h2 && wr_hi_idx == 4'h3 && {wr_hi_data, wr_lo_data}
        == $past(file_word) * $past(default_working_register))
        else $error("file multiply wrong");

endmodule

// >>> core/imu_defines.svh
// constants of the integer multiply unit
`ifndef IMU_DEFINES_SVH
`define IMU_DEFINES_SVH

// ==========================================================
// widths
`define IMU_WORD_W 16
`define IMU_IDX_W 4
`define IMU_LIT_W 5
`define IMU_ACC_W 40

// ==========================================================
// fixed destinations of the file-register form
`define IMU_FILE_LO_IDX 4'h2
`define IMU_FILE_HI_IDX 4'h3

// ==========================================================
// timing counts in instruction cycles
`define IMU_BASE_CYCLES 1
`define IMU_SFR_EXTRA_CYCLES 1

// ==========================================================
// reset values
`define IMU_RST_WORD 16'h0000
`define IMU_RST_ACC 40'h00_0000_0000

`endif

// >>> core/imu_pkg.sv
// types of the integer multiply unit
package imu_pkg;

    // ==========================================================
    // result shape of a multiply
    typedef enum logic [2:0] {
        IMU_FORM_PAIR_REG,
        IMU_FORM_WORD_REG,
        IMU_FORM_ACC_REG,
        IMU_FORM_ACC_LIT,
        IMU_FORM_PAIR_LIT,
        IMU_FORM_WORD_LIT,
        IMU_FORM_FILE
    } imu_form_t;

    // ==========================================================
    // operand signedness, first letter for the base operand
    typedef enum logic [1:0] {
        IMU_SIGN_SS,
        IMU_SIGN_SU,
        IMU_SIGN_US,
        IMU_SIGN_UU
    } imu_sign_t;

    // ==========================================================
    // sequencing phase
    typedef enum logic {
        IMU_PH_IDLE,
        IMU_PH_SFR_WAIT
    } imu_phase_t;

endpackage

// >>> core/imu_mul_if.sv
// operand and product carrier between the unit and its multiplier array
`timescale 1ns/1ps
interface imu_mul_if;
    logic [15:0] base_operand;
    logic [15:0] source_operand;
    logic base_signed;
    logic source_signed;
    logic [31:0] product;

    // ==========================================================
    // unit side drives operands
    modport requester (
        output base_operand,
        output source_operand,
        output base_signed,
        output source_signed,
        input product
    );

    // ==========================================================
    // array side returns the product
    modport multiplier (
        input base_operand,
        input source_operand,
        input base_signed,
        input source_signed,
        output product
    );
endinterface

// >>> core/imu_mul_array.sv
// combinational 16x16 multiplier with per-operand signedness
`timescale 1ns/1ps
module imu_mul_array
    import imu_pkg::*;
(
    // operands and product
    imu_mul_if.multiplier mul
);

    logic signed [16:0] base_ext;
    logic signed [16:0] source_ext;
    logic signed [33:0] full_product;

    // ==========================================================
    // extend each operand by its sign bit or by zero
    always_comb
    begin
        base_ext = {mul.base_signed & mul.base_operand[15], mul.base_operand};
        source_ext = {mul.source_signed & mul.source_operand[15], mul.source_operand};
        full_product = base_ext * source_ext;
    end

    // double-width product, exact for all sign combinations
    assign mul.product = full_product[31:0];

endmodule

// >>> tb/imu_regfile_model.sv
// register file model standing at the far side of the multiply unit
`timescale 1ns/1ps
module imu_regfile_model
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // write ports from the unit
    input wire logic wr_lo_en,
    input wire logic [3:0] wr_lo_idx,
    input wire logic [15:0] wr_lo_data,
    input wire logic wr_hi_en,
    input wire logic [3:0] wr_hi_idx,
    input wire logic [15:0] wr_hi_data,
    // register contents seen by the bench
    output logic [15:0] regs [16]
);
    // ==========================================================
    // register writes, both words of a pair land on the same edge
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < 16; i++)
                regs[i] <= 16'h0000;
        end
        else
        begin
            if (wr_lo_en)
                regs[wr_lo_idx] <= wr_lo_data;
            if (wr_hi_en)
                regs[wr_hi_idx] <= wr_hi_data;
        end
    end
endmodule

// >>> tb/tb_integer_multiply_unit.sv
// self-checking bench of the integer multiply unit
`timescale 1ns/1ps
module tb_integer_multiply_unit;
    import imu_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic issue_valid = 1'b0;
    imu_form_t issue_form = IMU_FORM_PAIR_REG;
    imu_sign_t issue_sign = IMU_SIGN_SS;
    logic issue_sfr_read = 1'b0;
    logic [3:0] issue_dest_idx = 4'h0;
    logic issue_acc_sel = 1'b0;
    logic [15:0] base_operand_register = 16'h0000;
    logic [15:0] source_operand_register = 16'h0000;
    logic [4:0] five_bit_immediate = 5'h00;
    logic [15:0] file_word = 16'h0000;
    logic [15:0] default_working_register = 16'h0000;
    logic wr_lo_en, wr_hi_en, acc_wr_en, acc_wr_sel, busy, done, illegal;
    logic [3:0] wr_lo_idx, wr_hi_idx;
    logic [15:0] wr_lo_data, wr_hi_data;
    logic [39:0] acc_wr_data;
    logic plain_done, plain_illegal, plain_acc_wr_en;
    logic [15:0] regs [16];
    logic [32:0] e_pair, e_word;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    // ==========================================================
    // clock, hang guard and instances
    always #50 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            end_sim();
        end
    end

    imu_top #(.MOTOR_CTRL(1'b1)) dut (.clock(clock), .arst_n(arst_n), .issue_valid(issue_valid),
        .issue_form(issue_form), .issue_sign(issue_sign), .issue_sfr_read(issue_sfr_read),
        .issue_dest_idx(issue_dest_idx), .issue_acc_sel(issue_acc_sel),
        .base_operand_register(base_operand_register), .source_operand_register(source_operand_register),
        .five_bit_immediate(five_bit_immediate), .file_word(file_word),
        .default_working_register(default_working_register), .wr_lo_en(wr_lo_en), .wr_lo_idx(wr_lo_idx),
        .wr_lo_data(wr_lo_data), .wr_hi_en(wr_hi_en), .wr_hi_idx(wr_hi_idx), .wr_hi_data(wr_hi_data),
        .acc_wr_en(acc_wr_en), .acc_wr_sel(acc_wr_sel), .acc_wr_data(acc_wr_data), .busy(busy),
        .done(done), .illegal(illegal));

    // variant without accumulator forms, fed the same requests
    imu_top #(.MOTOR_CTRL(1'b0)) dut_plain (.clock(clock), .arst_n(arst_n), .issue_valid(issue_valid),
        .issue_form(issue_form), .issue_sign(issue_sign), .issue_sfr_read(issue_sfr_read),
        .issue_dest_idx(issue_dest_idx), .issue_acc_sel(issue_acc_sel),
        .base_operand_register(base_operand_register), .source_operand_register(source_operand_register),
        .five_bit_immediate(five_bit_immediate), .file_word(file_word),
        .default_working_register(default_working_register), .wr_lo_en(), .wr_lo_idx(), .wr_lo_data(),
        .wr_hi_en(), .wr_hi_idx(), .wr_hi_data(), .acc_wr_en(plain_acc_wr_en), .acc_wr_sel(),
        .acc_wr_data(), .busy(), .done(plain_done), .illegal(plain_illegal));

    imu_regfile_model model (.clock(clock), .arst_n(arst_n), .wr_lo_en(wr_lo_en), .wr_lo_idx(wr_lo_idx),
        .wr_lo_data(wr_lo_data), .wr_hi_en(wr_hi_en), .wr_hi_idx(wr_hi_idx), .wr_hi_data(wr_hi_data),
        .regs(regs));

    // ==========================================================
    // expected product, bit 32 tells whether the accumulator extension is signed
    function automatic logic [32:0] exp_prod(input imu_form_t f, input imu_sign_t s);
        logic bs, ws;
        logic [15:0] bo, wo;
        logic signed [16:0] xa, xb;
        logic signed [33:0] p;
        bs = (s == IMU_SIGN_SS) || (s == IMU_SIGN_SU);
        ws = (s == IMU_SIGN_SS) || (s == IMU_SIGN_US);
        bo = base_operand_register;
        wo = source_operand_register;
        if (f inside {IMU_FORM_ACC_LIT, IMU_FORM_PAIR_LIT, IMU_FORM_WORD_LIT})
        begin
            wo = {11'h000, five_bit_immediate};
            ws = 1'b0;
        end
        if (f == IMU_FORM_FILE)
        begin
            bo = file_word;
            wo = default_working_register;
            bs = 1'b0;
            ws = 1'b0;
        end
        xa = {bs & bo[15], bo};
        xb = {ws & wo[15], wo};
        p = xa * xb;
        return {bs | ws, p[31:0]};
    endfunction

    // compare and count
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // issue the request on the inputs and check its result cycle
    task automatic do_op();
        logic [32:0] e;
        logic pair, acc, sel;
        logic [3:0] lo;
        e = exp_prod(issue_form, issue_sign);
        pair = issue_form inside {IMU_FORM_PAIR_REG, IMU_FORM_PAIR_LIT, IMU_FORM_FILE};
        acc = issue_form inside {IMU_FORM_ACC_REG, IMU_FORM_ACC_LIT};
        lo = (issue_form == IMU_FORM_FILE) ? 4'h2 : issue_dest_idx;
        sel = issue_acc_sel;
        issue_valid = 1'b1;
        if (issue_sfr_read)
        begin
            @(negedge clock);
            chk({busy, done}, 2'b10);
            // request still held during the stall must be ignored, latched operands used
            base_operand_register = ~base_operand_register;
            source_operand_register = ~source_operand_register;
        end
        @(negedge clock);
        chk({done, busy, plain_done, plain_illegal, plain_acc_wr_en}, {2'b10, !acc, acc, 1'b0});
        chk({wr_lo_en, wr_hi_en, acc_wr_en}, {!acc, pair, acc});
        if (acc)
        begin
            chk(acc_wr_sel, sel);
            chk(acc_wr_data, {{8{e[32] & e[31]}}, e[31:0]});
        end
        else if (pair)
        begin
            chk({wr_lo_idx, wr_hi_idx}, {lo, lo + 4'h1});
            chk({wr_hi_data, wr_lo_data}, e[31:0]);
        end
        else
            chk({wr_lo_idx, wr_lo_data}, {lo, e[15:0]});
    endtask

    task automatic end_sim();
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // main sequence: corners of every form and sign, then random traffic
    initial
    begin
        void'($urandom(17842));
        repeat (3) @(negedge clock);
        arst_n = 1'b1;
        for (int i = 0; i < 300; i++)
        begin
            issue_form = imu_form_t'(3'(i % 7));
            issue_sign = imu_sign_t'(2'((i / 7) % 4));
            if (i < 28)
            begin
                base_operand_register = i[0] ? 16'h8000 : 16'hFFFF;
                source_operand_register = i[1] ? 16'hFFFF : 16'h8000;
                five_bit_immediate = 5'h1F;
                file_word = 16'hFFFF;
                default_working_register = 16'h8000;
                issue_dest_idx = 4'hF;
                issue_acc_sel = i[1];
            end
            else
            begin
                base_operand_register = 16'($urandom);
                source_operand_register = 16'($urandom);
                five_bit_immediate = 5'($urandom);
                file_word = 16'($urandom);
                default_working_register = 16'($urandom);
                issue_dest_idx = 4'($urandom);
                issue_acc_sel = 1'($urandom);
                issue_sfr_read = ($urandom_range(3) == 0);
            end
            do_op();
            issue_sfr_read = 1'b0;
        end
        issue_valid = 1'b0;
        @(negedge clock);
        chk({done, illegal, busy, wr_lo_en, wr_hi_en, acc_wr_en}, 6'h00);
        // pair then word to the same destination, the upper neighbour must survive
        issue_form = IMU_FORM_PAIR_REG;
        issue_dest_idx = 4'h6;
        e_pair = exp_prod(IMU_FORM_PAIR_REG, issue_sign);
        do_op();
        issue_form = IMU_FORM_WORD_REG;
        base_operand_register = ~base_operand_register;
        e_word = exp_prod(IMU_FORM_WORD_REG, issue_sign);
        do_op();
        issue_valid = 1'b0;
        @(negedge clock);
        chk(regs[7], e_pair[31:16]);
        chk(regs[6], e_word[15:0]);
        end_sim();
    end
endmodule
